// ==== rsf_reset_source_flags.sv ====
`timescale 1ns/10ps

module rsf_reset_source_flags
    import rsf_pkg::*;
#(
    parameter int MCD_TIMEOUT = MCD_TIMEOUT_CYC
)(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output      logic [31:0] wb_dat_o,
    output      logic        wb_ack_o,
    input  wire logic        rstPinIn,
    output      logic        rstPinOut,
    output      logic        rstPinOe,
    input  wire logic        watchdogTimeout,
    input  wire logic        flashFault,
    input  wire logic        comparatorOut,
    input  wire logic        supplyLow,
    input  wire logic        sysClkEdge,
    output      logic        sysResetOut,
    output      logic        coreRun
);

    // ========================================
    // Helpers

    function automatic logic cntDone(
        input logic [CNT_W-1:0] cnt,
        input logic [CNT_W-1:0] lim
    );
        cntDone = (cnt >= lim);
    endfunction

    function automatic logic [CNT_W-1:0] cntStep(
        input logic [CNT_W-1:0] cnt
    );
        cntStep = cnt + CNT_W'(1);
    endfunction

    // Clear beats a write in the same cycle, so a reset never
    // leaves a source armed behind it
    function automatic logic enableNext(
        input logic cur,
        input logic clr,
        input logic clrVal,
        input logic load,
        input logic wrBit
    );
        if (clr) begin
            enableNext = clrVal;
        end else if (load) begin
            enableNext = wrBit;
        end else begin
            enableNext = cur;
        end
    endfunction

    localparam logic [CNT_W-1:0] MCD_LIM   = CNT_W'(MCD_TIMEOUT);
    localparam logic [CNT_W-1:0] HOLD_LIM  = CNT_W'(HOLD_MIN_CYC);
    localparam logic [CNT_W-1:0] START_LIM = CNT_W'(START_DELAY_CYC);
    localparam logic [CNT_W-1:0] CNT_ZERO  = '0;

    // ========================================
    // State

    rsf_seq_t         seq_reg;
    rsf_seq_t         seq_next;
    logic [CNT_W-1:0] seqCnt_reg;
    logic [CNT_W-1:0] seqCnt_next;
    logic [CNT_W-1:0] mcdCnt_reg;
    logic [CNT_W-1:0] mcdCnt_next;
    logic [6:0]       cause_reg;
    logic [6:0]       cause_next;
    logic             compEn_reg;
    logic             mcdEn_reg;
    logic             vmonEn_reg;
    logic             softReq_reg;
    logic             compEn_next;
    logic             mcdEn_next;
    logic             vmonEn_next;
    logic             softReq_next;
    logic             driveReg_reg;
    logic             driveReg_next;
    logic             ack_reg;
    logic [31:0]      dat_reg;

    // ========================================
    // Bus decode

    wire busReq    = wb_cyc_i && wb_stb_i;
    wire busStart  = busReq && !ack_reg;
    wire regHit    = (wb_adr_i[31:2] == CAUSE_REG_INDEX);
    wire lane0     = wb_sel_i[0];
    wire busWrite  = busReq && ack_reg && wb_we_i && regHit && lane0;
    wire inRun     = (seq_reg == SEQ_RUN);
    wire regWrite  = busWrite && inRun;

    // Flags on read, enables on write, so a read-modify-write
    // turns a stale flag into an enable
    wire [REG_W-1:0] readValue = {
        UNUSED_READ,
        cause_reg[BIT_FLASH],
        cause_reg[BIT_COMP],
        cause_reg[BIT_SOFT],
        cause_reg[BIT_WDOG],
        cause_reg[BIT_CLKLOSS],
        cause_reg[BIT_POWERON],
        cause_reg[BIT_PIN]
    };

    // Unmapped reads return zero rather than a copy of the flags
    wire [31:0] readWord = regHit ?
        {{(32-REG_W){1'b0}}, readValue} : 32'h00000000;

    // ========================================
    // Reset requests

    // Own drive of the pin is not taken as an outside pin reset
    wire pinReq   = !rstPinIn && !rstPinOe;
    wire compReq  = compEn_reg && !comparatorOut;
    wire vmonReq  = vmonEn_reg && supplyLow;
    wire mcdFire  = mcdEn_reg && cntDone(mcdCnt_reg, MCD_LIM);
    wire wdogReq  = watchdogTimeout;
    wire flashReq = flashFault;
    wire softReq  = softReq_reg;

    wire anyReq   = pinReq || compReq || vmonReq || mcdFire ||
                    wdogReq || flashReq || softReq;

    // Level sources; reset entry clears the comparator and supply enables, so only the pin keeps the system held while it stands
    wire levelHeld = pinReq || compReq || vmonReq;

    // Supply monitor reset reports as power-on only; the rest is left
    // cleared since it would carry no meaning
    wire [6:0] causeCaught = vmonReq ? CAUSE_POR_VALUE :
        {flashReq,
         compReq,
         softReq,
         wdogReq,
         mcdFire,
         1'b0,
         pinReq};

    // Pin driven only for resets other than flash fault, software or pin
    wire drivesPin = vmonReq || compReq || mcdFire || wdogReq;

    // ========================================
    // Sequencer

    // Hold stretches while a level source stands, but reset entry clears the comparator and supply enables,
    // so only a pin request that is still there keeps the core from restarting
    wire holdDone  = cntDone(seqCnt_reg, HOLD_LIM);
    wire startDone = cntDone(seqCnt_reg, START_LIM);

    always_comb begin
        seq_next      = seq_reg;
        seqCnt_next   = seqCnt_reg;
        cause_next    = cause_reg;
        driveReg_next = driveReg_reg;
        case (seq_reg)
            SEQ_RUN: begin
                if (anyReq) begin
                    seq_next      = SEQ_HOLD;
                    seqCnt_next   = CNT_ZERO;
                    cause_next    = causeCaught;
                    driveReg_next = drivesPin;
                end
            end
            SEQ_HOLD: begin
                if (!holdDone) begin
                    seqCnt_next = cntStep(seqCnt_reg);
                end else if (!levelHeld) begin
                    seq_next      = SEQ_START;
                    seqCnt_next   = CNT_ZERO;
                    driveReg_next = 1'b0;
                end
            end
            SEQ_START: begin
                if (startDone) begin
                    seq_next = SEQ_RUN;
                end else begin
                    seqCnt_next = cntStep(seqCnt_reg);
                end
            end
            default: begin
                seq_next      = SEQ_START;
                seqCnt_next   = CNT_ZERO;
                driveReg_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            seq_reg    <= SEQ_START;
            seqCnt_reg <= CNT_ZERO;
        end else if (ce) begin
            seq_reg    <= seq_next;
            seqCnt_reg <= seqCnt_next;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cause_reg <= CAUSE_POR_VALUE;
        end else if (ce) begin
            cause_reg <= cause_next;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            driveReg_reg <= 1'b0;
        end else if (ce) begin
            driveReg_reg <= driveReg_next;
        end
    end

    // ========================================
    // Clock-loss detector

    // Counts detector clocks since the last supervised clock edge;
    // it runs only while enabled so a stale count cannot fire
    // Limitation: the count runs on clk, so the watched clock must
    // arrive as sysClkEdge pulses already brought into this domain
    wire mcdClear = !mcdEn_reg || sysClkEdge || !inRun;
    wire mcdStep  = !cntDone(mcdCnt_reg, MCD_LIM);

    always_comb begin
        mcdCnt_next = mcdCnt_reg;
        if (mcdClear) begin
            mcdCnt_next = CNT_ZERO;
        end else if (mcdStep) begin
            mcdCnt_next = cntStep(mcdCnt_reg);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mcdCnt_reg <= CNT_ZERO;
        end else if (ce) begin
            mcdCnt_reg <= mcdCnt_next;
        end
    end

    // ========================================
    // Enables and software force

    // Every system reset drops the enables; software must set them again
    wire sysResetting = inRun && anyReq;

    assign compEn_next  = enableNext(compEn_reg, sysResetting, 1'b0,
                                     regWrite, wb_dat_i[BIT_COMP]);
    assign mcdEn_next   = enableNext(mcdEn_reg, sysResetting, 1'b0,
                                     regWrite, wb_dat_i[BIT_CLKLOSS]);
    assign vmonEn_next  = enableNext(vmonEn_reg, sysResetting,
                                     VMON_EN_RESET, regWrite,
                                     wb_dat_i[BIT_POWERON]);
    assign softReq_next = enableNext(softReq_reg, sysResetting, 1'b0,
                                     regWrite, wb_dat_i[BIT_SOFT]);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            compEn_reg <= 1'b0;
        end else if (ce) begin
            compEn_reg <= compEn_next;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mcdEn_reg <= 1'b0;
        end else if (ce) begin
            mcdEn_reg <= mcdEn_next;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            vmonEn_reg <= VMON_EN_RESET;
        end else if (ce) begin
            vmonEn_reg <= vmonEn_next;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            softReq_reg <= 1'b0;
        end else if (ce) begin
            softReq_reg <= softReq_next;
        end
    end

    // ========================================
    // Wishbone answer

    // One wait state: ack rises the cycle after the request and
    // falls the cycle after that
    // Writes outside RUN are still answered, so the bus never stalls
    // across a reset; they are simply dropped
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_reg <= 1'b0;
        end else if (ce) begin
            ack_reg <= busStart;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dat_reg <= 32'h00000000;
        end else if (ce && busStart) begin
            dat_reg <= readWord;
        end
    end

    // ========================================
    // Outputs

    assign wb_ack_o    = ack_reg;
    assign wb_dat_o    = dat_reg;
    assign rstPinOut   = 1'b0;
    assign rstPinOe    = driveReg_reg;
    assign sysResetOut = !inRun;
    assign coreRun     = inRun;

endmodule

// ==== rsf_pkg.sv ====
package rsf_pkg;

    // ========================================
    // Clock
    localparam int CLK_HZ        = 20_000_000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int CLK_PER_US    = CLK_HZ / 1_000_000;

    // ========================================
    // Register map (offset is a word index, byte address = 4 * index)
    localparam logic [29:0] CAUSE_REG_INDEX = 30'h000000ef;
    localparam int          REG_W           = 8;

    // Field positions of reset_cause_and_enable
    localparam int BIT_UNUSED   = 7;
    localparam int BIT_FLASH    = 6;
    localparam int BIT_COMP     = 5;
    localparam int BIT_SOFT     = 4;
    localparam int BIT_WDOG     = 3;
    localparam int BIT_CLKLOSS  = 2;
    localparam int BIT_POWERON  = 1;
    localparam int BIT_PIN      = 0;

    // Cause flags after power-on: only the power-on flag set
    localparam logic [6:0] CAUSE_POR_VALUE = 7'h02;
    localparam logic [6:0] CAUSE_NONE      = 7'h00;
    localparam logic       UNUSED_READ     = 1'b1;
    localparam logic       VMON_EN_RESET   = 1'b0;

    // ========================================
    // Timing
    localparam int MCD_TIMEOUT_US     = 350;
    localparam int MCD_TIMEOUT_MAX_US = 650;
    localparam int MCD_TIMEOUT_CYC    = MCD_TIMEOUT_US * CLK_PER_US;
    localparam int START_DELAY_MAX_US = 350;
    localparam int START_DELAY_NS     = 800;
    localparam int START_DELAY_CYC    =
        (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_MIN_NS        = 1000;
    localparam int HOLD_MIN_CYC       =
        (HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W              = 16;

    // ========================================
    // Sequencer states
    typedef enum logic [1:0] {
        SEQ_RUN,
        SEQ_HOLD,
        SEQ_START
    } rsf_seq_t;

endpackage

// ==== rsf_reset_source_flags_props.sv ====
`timescale 1ns/10ps
// ========================================
// Bus and reset sequencing checks
module rsf_reset_source_flags_props
    import rsf_pkg::*;
#(
    parameter int MCD_TIMEOUT = MCD_TIMEOUT_CYC
)(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        ce,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        rstPinIn,
    input wire logic        rstPinOut,
    input wire logic        rstPinOe,
    input wire logic        watchdogTimeout,
    input wire logic        flashFault,
    input wire logic        comparatorOut,
    input wire logic        supplyLow,
    input wire logic        sysClkEdge,
    input wire logic        sysResetOut,
    input wire logic        coreRun
);
    wire regHit = (wb_adr_i == {CAUSE_REG_INDEX, 2'b00});
    wire softWr = wb_ack_o && wb_we_i && regHit && wb_sel_i[0] && wb_dat_i[4];
    default clocking dc @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce
        |=> wb_ack_o) else $error("ack missing");
    AST_ACK_PULSE: assert property (wb_ack_o && ce |=> !wb_ack_o)
        else $error("ack held");
    AST_TOP_BIT: assert property (wb_ack_o && !wb_we_i && regHit
        |-> wb_dat_o[7] && wb_dat_o[31:8] == 24'h0) else $error("bit7");
    AST_SOFT_RESET: assert property (softWr && coreRun
        |-> ##[1:3] (sysResetOut && !rstPinOe)) else $error("soft reset");
    AST_WDOG: assert property (watchdogTimeout && coreRun && ce
        |=> sysResetOut && rstPinOe) else $error("watchdog reset");
    AST_FLASH: assert property (flashFault && coreRun && rstPinIn
        && !watchdogTimeout |=> sysResetOut && !rstPinOe) else $error("flash");
    AST_PIN: assert property (!rstPinIn && !rstPinOe && coreRun
        |=> sysResetOut && !rstPinOe) else $error("pin reset");
    AST_RESTART: assert property ($fell(rstPinOe)
        |-> ##[1:24] coreRun) else $error("late restart");
    AST_RUN_LEVEL: assert property (coreRun == !sysResetOut)
        else $error("run level");
endmodule

bind rsf_reset_source_flags rsf_reset_source_flags_props #(
    .MCD_TIMEOUT(MCD_TIMEOUT)
) uChk (.clk(clk), .sys_rst(sys_rst), .ce(ce), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rstPinIn(rstPinIn), .rstPinOut(rstPinOut),
    .rstPinOe(rstPinOe), .watchdogTimeout(watchdogTimeout),
    .flashFault(flashFault), .comparatorOut(comparatorOut),
    .supplyLow(supplyLow), .sysClkEdge(sysClkEdge),
    .sysResetOut(sysResetOut), .coreRun(coreRun));

// ==== rsf_reset_source_flags_tb.sv ====
`timescale 1ns/10ps
`define CHK(got, exp, msg) begin n_compared++; \
    if ((got) !== (exp)) begin failures++; \
    $display("FAIL t=%0t %s", $time, msg); end end
// ========================================
// Testbench
module rsf_reset_source_flags_tb
    import rsf_pkg::*;
;
    localparam int MCD = 20;
    localparam logic [31:0] ADR = {CAUSE_REG_INDEX, 2'b00};
    logic        clk = 1'b0, sysRst = 1'b1, ce = 1'b1;
    logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
    logic [31:0] wbAdr = 32'h0, wbDat = 32'h0, wbDatO;
    logic [3:0]  wbSel = 4'hf;
    logic        pinExt = 1'b1, wdog = 1'b0, flash = 1'b0, compOut = 1'b1;
    logic        supLow = 1'b0, clkEdge = 1'b1;
    logic        pinOut, pinOe, sysResetOut, coreRun;
    logic [7:0]  rd;
    int          failures = 0, n_compared = 0, cycles = 0;
    // Pin is open drain: our drive wins over the external level
    wire rstPin = pinOe ? 1'b0 : pinExt;

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    rsf_reset_source_flags #(.MCD_TIMEOUT(MCD)) uut (.clk(clk),
        .sys_rst(sysRst), .ce(ce), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
        .rstPinIn(rstPin), .rstPinOut(pinOut), .rstPinOe(pinOe),
        .watchdogTimeout(wdog), .flashFault(flash),
        .comparatorOut(compOut), .supplyLow(supLow),
        .sysClkEdge(clkEdge), .sysResetOut(sysResetOut), .coreRun(coreRun));

    task automatic stop_test;
        if (failures == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Generous ceiling: the whole run needs well under 2000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("FAIL t=%0t timeout", $time);
            stop_test();
        end
    end

    // ========================================
    // Bus and wait helpers
    task automatic bus(input logic we, input logic [31:0] adr,
                       input logic [7:0] dat);
        int n;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDat <= {24'h0, dat};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1);
        rd = wbDatO[7:0];
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        `CHK(n, 2, "ack latency")
    endtask

    task automatic readExp(input logic [7:0] exp, input string msg);
        bus(1'b0, ADR, 8'h00);
        `CHK(rd, exp, msg)
    endtask

    task automatic waitCore(input logic lvl);
        int n;
        n = 0;
        while (coreRun !== lvl && n < 400) begin
            @(posedge clk);
            n++;
        end
        `CHK(coreRun, lvl, "core run level")
    endtask

    // ========================================
    // Scenarios
    task automatic t_por;
        waitCore(1'b1);
        readExp(8'h82, "after power on");
        bus(1'b1, ADR, 8'h00);
        readExp(8'h82, "flags kept");
        bus(1'b1, ADR + 32'h4, 8'h10);
        repeat (6) @(posedge clk);
        `CHK(coreRun, 1'b1, "stray soft reset")
        bus(1'b0, ADR + 32'h4, 8'h00);
        `CHK(rd, 8'h00, "unmapped read")
    endtask

    task automatic t_wdog;
        @(posedge clk);
        wdog <= 1'b1;
        @(posedge clk);
        wdog <= 1'b0;
        waitCore(1'b0);
        waitCore(1'b1);
        readExp(8'h88, "watchdog flag");
    endtask

    task automatic t_ce;
        @(posedge clk);
        ce <= 1'b0;
        wdog <= 1'b1;
        repeat (3) @(posedge clk);
        wdog <= 1'b0;
        ce <= 1'b1;
        @(posedge clk);
        `CHK(coreRun, 1'b1, "frozen block reset")
        readExp(8'h88, "frozen flags");
        sysRst <= 1'b1;
        repeat (2) @(posedge clk);
        sysRst <= 1'b0;
        waitCore(1'b1);
        readExp(8'h82, "power on again");
    endtask

    task automatic t_flash;
        @(posedge clk);
        flash <= 1'b1;
        @(posedge clk);
        flash <= 1'b0;
        waitCore(1'b0);
        waitCore(1'b1);
        readExp(8'hc0, "flash flag");
    endtask

    task automatic t_soft;
        bus(1'b1, ADR, 8'h12);
        waitCore(1'b0);
        waitCore(1'b1);
        readExp(8'h90, "soft flag");
    endtask

    task automatic t_pin;
        @(posedge clk);
        pinExt <= 1'b0;
        repeat (3) @(posedge clk);
        pinExt <= 1'b1;
        waitCore(1'b0);
        waitCore(1'b1);
        readExp(8'h81, "pin flag");
    endtask

    task automatic t_comp;
        @(posedge clk);
        compOut <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK(coreRun, 1'b1, "comparator disabled")
        bus(1'b1, ADR, 8'h20);
        waitCore(1'b0);
        compOut <= 1'b1;
        waitCore(1'b1);
        readExp(8'ha0, "comparator flag");
    endtask

    task automatic t_mcd;
        bus(1'b1, ADR, 8'h04);
        clkEdge <= 1'b0;
        repeat (MCD - 5) @(posedge clk);
        `CHK(coreRun, 1'b1, "clock loss early")
        repeat (10) @(posedge clk);
        `CHK(coreRun, 1'b0, "clock loss late")
        clkEdge <= 1'b1;
        waitCore(1'b1);
        readExp(8'h84, "clock loss flag");
    endtask

    task automatic t_supply;
        bus(1'b1, ADR, 8'h02);
        supLow <= 1'b1;
        waitCore(1'b0);
        supLow <= 1'b0;
        waitCore(1'b1);
        readExp(8'h82, "supply flag");
    endtask

    initial begin
        repeat (2) @(posedge clk);
        sysRst <= 1'b0;
        t_por();
        t_wdog();
        t_ce();
        t_flash();
        t_soft();
        t_pin();
        t_comp();
        t_mcd();
        t_supply();
        stop_test();
    end
endmodule
